/* rtl/itb_defines.vh */
`ifndef ITB_DEFINES_VH
`define ITB_DEFINES_VH

// Register byte offsets
`define ITB_OFS_MODE 8'h00
`define ITB_OFS_DIV 8'h04
`define ITB_OFS_STATUS 8'h08
`define ITB_OFS_CLEAR 8'h0C
`define ITB_OFS_MASK 8'h10

// Reset values
`define ITB_RST_MODE 4'h0
`define ITB_RST_DIV 2'h0
`define ITB_RST_MASK 1'b1

// Field positions
`define ITB_MODE_TB_BIT 3
`define ITB_FLAG_OVF_BIT 0
`define ITB_MASK_OVF_BIT 0

// Clock and timing
`define ITB_REF_FREQ_HZ 50000000
`define ITB_SUBOSC_FREQ_HZ 32768
`define ITB_SUBOSC_CYC (`ITB_REF_FREQ_HZ / `ITB_SUBOSC_FREQ_HZ)
`define ITB_SUB_DIV 8

// Counter extremes
`define ITB_CNT_MAX 8'hFF
`define ITB_CNT_ZERO 8'h00

// AHB encodings
`define ITB_HTRANS_NONSEQ 2'h2
`define ITB_HSIZE_WORD 3'h2

`endif

/* rtl/itb_interval_timer.v */
`timescale 1ns/100ps
`include "itb_defines.vh"

// Overview of operation
// - Eight-bit up counter advances once per selected input clock tick.
// - Counter value is never returned by reads nor loaded by writes.
// - Reset and stop mode force the counter to zero.
// - Tick at full count signals overflow and sets overflow request flag.
// - Counter wraps to zero and continues; overflow every 256 ticks.
// - Interrupt requested while flag set and overflow mask is zero.
// - Flag stays set after interrupt; software must clear it.
// - Time-base select zero means free-running; reset clears it.
// - A mode write that selects free-running mode never clears the counter.
// - Free codes 0-7 pick system taps 2048,1024,512,128,32,8,4,2.
// - Time-base codes pick subclock taps 32,16,8,2, half-cycle, unused.
// - Writing 111 to top mode bits clears subclock prescaler and counter.
// - System prescaler clock is oscillator over 4, 8, 16 or 32.
// - Without time-base option, top bit ignored and divisor fixed at 4.
// - Subclock prescaler runs on subclock oscillator divided by eight.
module itb_interval_timer #(
  parameter TB_VARIANT = 1
) (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_stop,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  output reg o_irq
);

  // Reference cycles per subclock oscillator cycle. The true ratio is
  // not a whole number, so the modelled subclock runs slightly fast.
  localparam integer SUBOSC_CYC = `ITB_SUBOSC_CYC;
  localparam integer SUBOSC_LAST_INT = SUBOSC_CYC - 1;
  localparam [10:0] SUBOSC_LAST = SUBOSC_LAST_INT[10:0];

  // Tap mask for the system prescaler: tick when low bits are all ones
  function [10:0] itb_sys_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: itb_sys_mask = 11'h7FF;
        3'h1: itb_sys_mask = 11'h3FF;
        3'h2: itb_sys_mask = 11'h1FF;
        3'h3: itb_sys_mask = 11'h07F;
        3'h4: itb_sys_mask = 11'h01F;
        3'h5: itb_sys_mask = 11'h007;
        3'h6: itb_sys_mask = 11'h003;
        default: itb_sys_mask = 11'h001;
      endcase
    end
  endfunction

  // Tap mask for the subclock prescaler
  function [4:0] itb_sub_mask;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: itb_sub_mask = 5'h1F;
        2'h1: itb_sub_mask = 5'h0F;
        2'h2: itb_sub_mask = 5'h07;
        default: itb_sub_mask = 5'h01;
      endcase
    end
  endfunction

  // Register word decode, used by the read path only; writes compare the captured offset
  function itb_hit;
    input [31:0] addr;
    input [7:0] ofs;
    begin
      itb_hit = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
    end
  endfunction

  reg [3:0] mode_r;
  reg [1:0] div_sel_r;
  reg mask_r;
  reg flag_r;
  reg [7:0] count_r;
  reg [4:0] base_cnt_r;
  reg [10:0] sys_presc_r;
  reg [10:0] subosc_cnt_r;
  reg [2:0] fw_cnt_r;
  reg [4:0] sub_presc_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  // Combinational selections and next values
  reg [4:0] base_last;
  reg count_tick;
  reg [31:0] rd_word_nxt;
  reg [7:0] count_nxt;
  reg flag_nxt;

  wire addr_phase;
  wire tb_mode;
  wire tcyc_tick;
  wire fx_tick;
  wire fw_tick;
  wire half_tick;
  wire sys_tap;
  wire sub_tap;
  wire overflow;
  wire mode_wr;
  wire clr_write;
  wire ctb_clear;
  wire flag_clr;
  wire div_wr;
  wire mask_wr;

  assign addr_phase = i_hsel && i_hready &&
                      (i_htrans == `ITB_HTRANS_NONSEQ);
  // The top mode bit only matters on the time-base variant
  assign tb_mode = (TB_VARIANT != 0) &&
                   mode_r[`ITB_MODE_TB_BIT];

  // Oscillator divider for the system prescaler input. The fixed
  // variant always divides by four whatever the register holds.
  // The tick compare is greater-or-equal so that shrinking the divisor
  // mid-count cannot leave the divider stuck above its new end point.
  always @* begin
    base_last = 5'd3;
    if (TB_VARIANT != 0) begin
      case (div_sel_r)
        2'h0: base_last = 5'd3;
        2'h1: base_last = 5'd7;
        2'h2: base_last = 5'd15;
        default: base_last = 5'd31;
      endcase
    end
  end
  assign tcyc_tick = (base_cnt_r >= base_last);

  // Subclock oscillator and its fixed divide by eight. The oscillator
  // is modelled by a counter on the reference clock, so every subclock
  // event is an enable pulse rather than a second clock domain.
  assign fx_tick = (subosc_cnt_r == SUBOSC_LAST);
  assign fw_tick = fx_tick && (fw_cnt_r == 3'h7);
  // Half of a subsystem cycle: every fourth oscillator tick
  assign half_tick = fx_tick && (fw_cnt_r[1:0] == 2'h3);

  // Prescaler taps as single-cycle enables; no derived clocks. A tap
  // fires when the low bits of its prescaler are all ones and the
  // prescaler is about to advance, which gives exactly one pulse per
  // tap period without any gated or divided clock.
  assign sys_tap = tcyc_tick &&
    ((sys_presc_r & itb_sys_mask(mode_r[2:0])) ==
     itb_sys_mask(mode_r[2:0]));
  assign sub_tap = fw_tick &&
    ((sub_presc_r & itb_sub_mask(mode_r[1:0])) ==
     itb_sub_mask(mode_r[1:0]));

  // Select the counter enable. Code 1101 and the clear codes 111x give
  // no ticks, so a clear write is never followed by a stray count.
  always @* begin
    count_tick = 1'b0;
    if (!tb_mode) begin
      count_tick = sys_tap;
    end else begin
      case (mode_r[2:0])
        3'h0, 3'h1, 3'h2, 3'h3: count_tick = sub_tap;
        3'h4: count_tick = half_tick;
        default: count_tick = 1'b0;
      endcase
    end
  end
  assign overflow = count_tick && (count_r == `ITB_CNT_MAX);

  // Data phase of a write. The address was captured one cycle earlier
  // and the write data stands now, so each register takes its new
  // value at the edge that ends the data phase.
  assign mode_wr = wr_pend_r && (wr_addr_r == `ITB_OFS_MODE);
  assign clr_write = wr_pend_r && (wr_addr_r == `ITB_OFS_CLEAR);
  assign div_wr = wr_pend_r && (wr_addr_r == `ITB_OFS_DIV);
  assign mask_wr = wr_pend_r && (wr_addr_r == `ITB_OFS_MASK);
  // Clear code needs the top bit set, so a free-running write never
  // clears the counter
  assign ctb_clear = mode_wr && (TB_VARIANT != 0) &&
                     (i_hwdata[3:1] == 3'h7);
  assign flag_clr = clr_write && i_hwdata[`ITB_FLAG_OVF_BIT];

  // Read data for the word named in this address phase. The counter
  // deliberately has no case here: software can never see its value,
  // so a read of any other offset simply returns zero.
  always @* begin
    rd_word_nxt = 32'h00000000;
    if (addr_phase && !i_hwrite) begin
      if (itb_hit(i_haddr, `ITB_OFS_MODE)) begin
        rd_word_nxt = {28'h0000000, mode_r};
      end else if (itb_hit(i_haddr, `ITB_OFS_DIV)) begin
        rd_word_nxt = {30'h00000000, div_sel_r};
      end else if (itb_hit(i_haddr, `ITB_OFS_STATUS)) begin
        rd_word_nxt = {31'h00000000, flag_r};
      end else if (itb_hit(i_haddr, `ITB_OFS_MASK)) begin
        rd_word_nxt = {31'h00000000, mask_r};
      end
    end
  end

  // AHB address phase capture and zero-wait response. Read data is
  // registered, so it stands for exactly the one data-phase cycle and
  // falls back to zero afterwards.
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_r <= addr_phase && i_hwrite &&
                   (i_haddr[31:8] == 24'h000000);
      wr_addr_r <= i_haddr[7:0];
      o_hrdata <= rd_word_nxt;
    end
  end

  // Control registers; stop mode returns the mode register to reset.
  // Stop deliberately leaves the divider and the mask as they are.
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      mode_r <= `ITB_RST_MODE;
      div_sel_r <= `ITB_RST_DIV;
      mask_r <= `ITB_RST_MASK;
    end else begin
      if (i_stop) begin
        mode_r <= `ITB_RST_MODE;
      end else if (mode_wr) begin
        mode_r <= i_hwdata[3:0];
      end
      // Changing this mid time-base run does not affect the count
      if (div_wr) begin
        div_sel_r <= i_hwdata[1:0];
      end
      if (mask_wr) begin
        mask_r <= i_hwdata[`ITB_MASK_OVF_BIT];
      end
    end
  end

  // System clock divider and system prescaler. Both restart from zero
  // after stop so the first tap after wake-up has a full period; the
  // prescaler itself is free running and wraps at its full width.
  always @(posedge i_ref_clk) begin
    if (!i_nrst || i_stop) begin
      base_cnt_r <= 5'd0;
      sys_presc_r <= 11'h000;
    end else begin
      if (tcyc_tick) begin
        base_cnt_r <= 5'd0;
        sys_presc_r <= sys_presc_r + 11'h001;
      end else begin
        base_cnt_r <= base_cnt_r + 5'd1;
      end
    end
  end

  // Subclock oscillator divider; it keeps running through a clear so
  // that the crystal phase is not disturbed
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      subosc_cnt_r <= 11'h000;
      fw_cnt_r <= 3'h0;
    end else if (fx_tick) begin
      subosc_cnt_r <= 11'h000;
      fw_cnt_r <= fw_cnt_r + 3'h1;
    end else begin
      subosc_cnt_r <= subosc_cnt_r + 11'h001;
    end
  end

  // Subclock prescaler. It advances once per subsystem cycle and is
  // cleared together with the counter by the time-base clear code, so
  // the first period after a clear is exact.
  always @(posedge i_ref_clk) begin
    if (!i_nrst || i_stop || ctb_clear) begin
      sub_presc_r <= 5'h00;
    end else if (fw_tick) begin
      sub_presc_r <= sub_presc_r + 5'h01;
    end
  end

  // Interval counter next value. The time-base clear code beats a
  // same-cycle tick, so the period after a clear starts from zero.
  always @* begin
    count_nxt = count_r;
    if (ctb_clear) begin
      count_nxt = `ITB_CNT_ZERO;
    end else if (count_tick) begin
      // Wraps from full count to zero by plain modulo arithmetic
      count_nxt = count_r + 8'h01;
    end
  end

  // Interval counter register; never loaded from the bus
  always @(posedge i_ref_clk) begin
    if (!i_nrst || i_stop) begin
      count_r <= `ITB_CNT_ZERO;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Sticky overflow flag next value. A new overflow beats a clear in
  // the same cycle, so an event is never lost to a late handler write.
  always @* begin
    flag_nxt = flag_r;
    if (overflow) begin
      flag_nxt = 1'b1;
    end else if (flag_clr) begin
      flag_nxt = 1'b0;
    end
  end

  // Flag register; stop mode leaves a pending request in place
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Interrupt level, taken from the flag's next value so the request
  // rises on the same edge as the flag. Acceptance by the CPU never
  // clears the flag; only a clear write does.
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= flag_nxt && !mask_r;
    end
  end

endmodule

/* verification/itb_interval_timer_chk.sv */
`timescale 1ns/100ps
`include "itb_defines.vh"
module itb_interval_timer_chk (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_stop,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire i_hready,
  input wire [31:0] o_hrdata,
  input wire o_hreadyout,
  input wire o_hresp,
  input wire o_irq
);
  wire aph = i_hsel && i_hready && i_htrans == `ITB_HTRANS_NONSEQ;
  wire ctl = (aph && i_hwrite) || i_stop;
  reg [3:0] hist_r;
  reg [15:0] gap_r;
  // Recent writes and cycles since last overflow-driven irq rise
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      hist_r <= 4'h0;
      gap_r <= 16'h0000;
    end else begin
      hist_r <= {hist_r[2:0], ctl};
      if ($rose(o_irq) && hist_r == 4'h0 && !ctl)
        gap_r <= 16'h0000;
      else if (gap_r != 16'hFFFF)
        gap_r <= gap_r + 16'h0001;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence quiet_s; hist_r == 4'h0 && !ctl; endsequence
  sequence void_rd_s;
    aph && !i_hwrite &&
      (i_haddr == `ITB_OFS_CLEAR || i_haddr > `ITB_OFS_MASK);
  endsequence
  irq_reset_a: assert property (disable iff (1'b0) !i_nrst |=> !o_irq)
    else $error("irq high after reset");
  okay_resp_a: assert property (!o_hresp)
    else $error("error response");
  ready_high_a: assert property (o_hreadyout)
    else $error("wait state inserted");
  idle_rdata_a: assert property (!$past(aph) |-> o_hrdata == 32'h0)
    else $error("read data outside data phase");
  void_rdata_a: assert property (void_rd_s |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  irq_hold_a: assert property (o_irq ##0 quiet_s |=> o_irq)
    else $error("irq dropped by itself");
  irq_fall_a: assert property ($fell(o_irq) |-> hist_r != 4'h0)
    else $error("irq fell without a write");
  min_period_a: assert property ($rose(o_irq) ##0 quiet_s |->
    gap_r >= 16'h07F8) else $error("overflows too close");
endmodule
bind itb_interval_timer itb_interval_timer_chk i_chk (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_stop(i_stop),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq(o_irq));

/* verification/itb_cpu_model.sv */
`timescale 1ns/100ps
`include "itb_defines.vh"
// CPU side: single word transfers; time base mode is entered only
// by the 1110 clear write, and the divisor is changed only in free mode
module itb_cpu_model (
  input wire i_ref_clk,
  input wire i_hready,
  input wire [31:0] i_hrdata,
  output logic o_hsel,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [31:0] o_hwdata
);
  // Idle bus at time zero
  initial begin
    o_hsel = 1'b0;
    o_haddr = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize = `ITB_HSIZE_WORD;
    o_hwdata = 32'h0;
  end
  // Address phase held until hready, then data phase until hready
  task xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge i_ref_clk);
    o_hsel <= 1'b1;
    o_htrans <= `ITB_HTRANS_NONSEQ;
    o_haddr <= a;
    o_hwrite <= w;
    do @(posedge i_ref_clk); while (i_hready !== 1'b1);
    o_hsel <= 1'b0;
    o_htrans <= 2'h0;
    o_hwdata <= d;
    do @(posedge i_ref_clk); while (i_hready !== 1'b1);
    r = i_hrdata;
  endtask
endmodule

/* verification/itb_interval_timer_tb_top.sv */
`timescale 1ns/100ps
`include "itb_defines.vh"
module itb_interval_timer_tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic stop = 1'b0;
  logic hsel, hwrite, hready, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  realtime t0;
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  itb_interval_timer i_dut (.i_ref_clk(ref_clk), .i_nrst(nrst),
    .i_stop(stop), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .o_irq(irq));
  itb_cpu_model i_cpu (.i_ref_clk(ref_clk), .i_hready(hready),
    .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
    .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
  task chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [31:0] a, d);
    i_cpu.xfer(1'b1, a, d, rd);
  endtask
  task rdc(input string nm, input logic [31:0] a, exp);
    i_cpu.xfer(1'b0, a, 32'h0, rd);
    chk(nm, rd, exp);
  endtask
  task wait_irq;
    while (irq !== 1'b1) @(posedge ref_clk);
  endtask
  task t_reset;
    chk("irq", {31'h0, irq}, 32'h0);
    rdc("mode", `ITB_OFS_MODE, 32'h0);
    rdc("div", `ITB_OFS_DIV, 32'h0);
    rdc("status", `ITB_OFS_STATUS, 32'h0);
    rdc("mask", `ITB_OFS_MASK, 32'h1);
    wr(32'h14, 32'hFF);
    rdc("unmapped", 32'h14, 32'h0);
    $display("t_reset done");
  endtask
  // Overflow period per divisor code with the fastest tap
  task t_period;
    for (int dv = 0; dv < 4; dv++) begin
      wr(`ITB_OFS_CLEAR, 32'h1);
      wr(`ITB_OFS_DIV, dv);
      wr(`ITB_OFS_MASK, 32'h0);
      wr(`ITB_OFS_MODE, 32'h7);
      wait_irq;
      t0 = $realtime;
      rdc("status", `ITB_OFS_STATUS, 32'h1);
      wr(`ITB_OFS_CLEAR, 32'h1);
      wr(`ITB_OFS_MODE, 32'h7);
      wait_irq;
      chk("period", 32'(int'(($realtime - t0) / 20)), 32'h800 << dv);
    end
    $display("t_period done");
  endtask
  task t_stop;
    stop <= 1'b1;
    repeat (2) @(posedge ref_clk);
    stop <= 1'b0;
    rdc("mode", `ITB_OFS_MODE, 32'h0);
    wr(`ITB_OFS_CLEAR, 32'h1);
    wr(`ITB_OFS_DIV, 32'h0);
    wr(`ITB_OFS_MODE, 32'h7);
    t0 = $realtime;
    wait_irq;
    chk("restart", ($realtime - t0) / 20 > 1990, 32'h1);
    $display("t_stop done");
  endtask
  task t_mask;
    wr(`ITB_OFS_MASK, 32'h1);
    wr(`ITB_OFS_CLEAR, 32'h1);
    repeat (2100) @(posedge ref_clk);
    chk("irq", {31'h0, irq}, 32'h0);
    rdc("status", `ITB_OFS_STATUS, 32'h1);
    wr(`ITB_OFS_CLEAR, 32'h1);
    rdc("status", `ITB_OFS_STATUS, 32'h0);
    $display("t_mask done");
  endtask
  // Free-mode mode write keeps the count; the 111x code clears it
  task t_clear;
    wr(`ITB_OFS_MASK, 32'h0);
    wr(`ITB_OFS_CLEAR, 32'h1);
    wait_irq;
    t0 = $realtime;
    wr(`ITB_OFS_CLEAR, 32'h1);
    repeat (1000) @(posedge ref_clk);
    wr(`ITB_OFS_MODE, 32'h7);
    wait_irq;
    chk("no clear", 32'(int'(($realtime - t0) / 20)), 32'h800);
    t0 = $realtime;
    wr(`ITB_OFS_CLEAR, 32'h1);
    repeat (1000) @(posedge ref_clk);
    wr(`ITB_OFS_MODE, 32'hE);
    wr(`ITB_OFS_MODE, 32'h7);
    wait_irq;
    chk("tb clear", ($realtime - t0) / 20 > 2100, 32'h1);
    $display("t_clear done");
  endtask
  task summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 100000) begin
      miscompares++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset;
    t_period;
    t_stop;
    t_mask;
    t_clear;
    summarize;
  end
endmodule
